// *** fsr_pkg.sv ***
`default_nettype none
package fsr_pkg;

	// Serial opcodes
	localparam logic [7:0] FSR_OP_STATUS_READ = 8'hd7;

	// Opcode length and status stream layout
	localparam logic [2:0] FSR_CMD_LAST_BIT = 3'h7;
	localparam logic [3:0] FSR_IDX_LOW_BYTE = 4'h0;
	localparam logic [3:0] FSR_IDX_HIGH_BYTE = 4'h8;
	localparam logic [3:0] FSR_IDX_LAST_BIT = 4'hf;

	// Capacity code; value is arbitrary
	localparam logic [3:0] FSR_CAPACITY_CODE = 4'h5;

	// Reset values
	localparam logic FSR_RST_MISMATCH = 1'b0;
	localparam logic FSR_RST_FAULT = 1'b0;
	localparam logic [7:0] FSR_RST_CMD = 8'h00;
	localparam logic [3:0] FSR_RST_CNT = 4'h0;

	// Field positions inside the high byte
	localparam int FSR_HI_FAULT_POS = 5;

	typedef enum logic [1:0] {
		FSR_ST_IDLE,
		FSR_ST_CMD,
		FSR_ST_STREAM,
		FSR_ST_IGNORE
	} fsr_state_type;

	typedef struct packed {
		logic ready;
		logic mismatch;
		logic [3:0] capacity;
		logic protect;
		logic page_binary;
	} fsr_stat_lo_type;

	typedef struct packed {
		logic ready;
		logic res6;
		logic write_erase_fault;
		logic res4;
		logic res3;
		logic [2:0] res2_0;
	} fsr_stat_hi_type;

endpackage
`default_nettype wire

// *** fsr_status_read.sv ***
// Overview of operation
// - Two-byte status is readable at any time except in sleep, even during program or erase.
// - Host selects and sends read opcode; device then drives status every clock.
// - After the second byte the low byte follows again while selected.
// - Status is sampled live per byte; ready appears in both bytes.
// - Deselect at any bit ends the read and floats the serial output.
// - Bit 7 of each byte is 0 while busy, 1 when ready.
// - Low byte bit 6 is last compare result: 0 match, 1 mismatch.
// - Low byte bits 5:2 hold a fixed read-only capacity code.
// - Low byte bit 1 is 1 when sector locking is enabled by any method.
// - Low byte bit 0 is 0 for 264-byte pages, 1 for 256-byte pages.
// - High byte bit 5 is 1 when the last erase or program failed.
// - Fault bit updates after every erase or program, never set on abort.
// - High byte bits 6, 4, 3 read 0; bits 2:0 reserved.
// - Compare result lands in low byte bit 6; busy shown while comparing.
// - In sleep the status read command is ignored.
`timescale 1ns/100ps
`default_nettype none
module fsr_status_read (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// Serial pins
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_o,
	// Core status
	input wire logic op_busy_i,
	input wire logic compare_start_i,
	input wire logic compare_done_i,
	input wire logic compare_mismatch_i,
	input wire logic protect_i,
	input wire logic page_binary_i,
	input wire logic wp_done_i,
	input wire logic wp_fail_i,
	input wire logic wp_abort_i,
	input wire logic sleep_i
);

	logic sck_s1_ff, sck_s2_ff, sck_d_ff;
	logic cs_s1_ff, cs_s2_ff;
	logic si_s1_ff, si_s2_ff;
	logic sck_rise, sck_fall;
	fsr_pkg::fsr_state_type state_ff;
	logic [7:0] cmd_ff;
	logic [7:0] nxt_cmd;
	logic [2:0] cmd_cnt_ff;
	logic [3:0] bit_idx_ff;
	logic [7:0] sh_ff;
	logic so_ff;
	logic mismatch_ff;
	logic compare_run_ff;
	logic fault_ff;
	logic ready_w;
	fsr_pkg::fsr_stat_lo_type stat_lo;
	fsr_pkg::fsr_stat_hi_type stat_hi;

	// Pins come from the host's domain
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_d_ff <= 1'b0;
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			si_s1_ff <= 1'b0;
			si_s2_ff <= 1'b0;
		end
		else
		begin
			sck_s1_ff <= sck_i;
			sck_s2_ff <= sck_s1_ff;
			sck_d_ff <= sck_s2_ff;
			cs_s1_ff <= cs_n_i;
			cs_s2_ff <= cs_s1_ff;
			si_s1_ff <= si_i;
			si_s2_ff <= si_s1_ff;
		end
	end

	assign sck_rise = sck_s2_ff & ~sck_d_ff & ~cs_s2_ff;
	assign sck_fall = ~sck_s2_ff & sck_d_ff & ~cs_s2_ff;
	assign nxt_cmd = {cmd_ff[6:0], si_s2_ff};

	// Compare in flight counts as busy
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			compare_run_ff <= 1'b0;
		else if (compare_done_i)
			compare_run_ff <= 1'b0;
		else if (compare_start_i)
			compare_run_ff <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mismatch_ff <= fsr_pkg::FSR_RST_MISMATCH;
		else if (compare_done_i)
			mismatch_ff <= compare_mismatch_i;
	end

	// Aborted operations leave the previous verdict in place
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fault_ff <= fsr_pkg::FSR_RST_FAULT;
		else if (wp_done_i && !wp_abort_i)
			fault_ff <= wp_fail_i;
	end

	assign ready_w = ~(op_busy_i | compare_run_ff);

	always_comb
	begin
		stat_lo.ready = ready_w;
		stat_lo.mismatch = mismatch_ff;
		stat_lo.capacity = fsr_pkg::FSR_CAPACITY_CODE;
		stat_lo.protect = protect_i;
		stat_lo.page_binary = page_binary_i;
		stat_hi.ready = ready_w;
		stat_hi.res6 = 1'b0;
		stat_hi.write_erase_fault = fault_ff;
		stat_hi.res4 = 1'b0;
		stat_hi.res3 = 1'b0;
		stat_hi.res2_0 = 3'h0;
	end

	// Command phase and stream control
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= fsr_pkg::FSR_ST_IDLE;
			cmd_ff <= fsr_pkg::FSR_RST_CMD;
			cmd_cnt_ff <= 3'h0;
		end
		else if (cs_s2_ff)
		begin
			state_ff <= fsr_pkg::FSR_ST_IDLE;
			cmd_cnt_ff <= 3'h0;
		end
		else
		begin
			unique case (state_ff)
				fsr_pkg::FSR_ST_IDLE:
					state_ff <= fsr_pkg::FSR_ST_CMD;
				fsr_pkg::FSR_ST_CMD:
					if (sck_rise)
					begin
						cmd_ff <= nxt_cmd;
						cmd_cnt_ff <= cmd_cnt_ff + 3'h1;
						if (cmd_cnt_ff == fsr_pkg::FSR_CMD_LAST_BIT)
						begin
							// No busy gating: status stays readable mid-operation
							if (nxt_cmd == fsr_pkg::FSR_OP_STATUS_READ && !sleep_i)
								state_ff <= fsr_pkg::FSR_ST_STREAM;
							else
								state_ff <= fsr_pkg::FSR_ST_IGNORE;
						end
					end
				fsr_pkg::FSR_ST_STREAM:
					state_ff <= fsr_pkg::FSR_ST_STREAM;
				fsr_pkg::FSR_ST_IGNORE:
					state_ff <= fsr_pkg::FSR_ST_IGNORE;
			endcase
		end
	end

	// Output shifter; each byte reloads fresh status at its first bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bit_idx_ff <= fsr_pkg::FSR_RST_CNT;
			sh_ff <= 8'h00;
			so_ff <= 1'b0;
		end
		else if (state_ff != fsr_pkg::FSR_ST_STREAM)
			bit_idx_ff <= fsr_pkg::FSR_RST_CNT;
		else if (sck_fall)
		begin
			bit_idx_ff <= bit_idx_ff + 4'h1;
			if (bit_idx_ff == fsr_pkg::FSR_IDX_LOW_BYTE)
			begin
				so_ff <= stat_lo.ready;
				sh_ff <= {stat_lo[6:0], 1'b0};
			end
			else if (bit_idx_ff == fsr_pkg::FSR_IDX_HIGH_BYTE)
			begin
				so_ff <= stat_hi.ready;
				sh_ff <= {stat_hi[6:0], 1'b0};
			end
			else
			begin
				so_ff <= sh_ff[7];
				sh_ff <= {sh_ff[6:0], 1'b0};
			end
		end
	end

	assign so_o = so_ff;
	assign so_oe_o = (state_ff == fsr_pkg::FSR_ST_STREAM);

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic load_lo, load_hi;
	assign load_lo = sck_fall && state_ff == fsr_pkg::FSR_ST_STREAM && bit_idx_ff == fsr_pkg::FSR_IDX_LOW_BYTE;
	assign load_hi = sck_fall && state_ff == fsr_pkg::FSR_ST_STREAM && bit_idx_ff == fsr_pkg::FSR_IDX_HIGH_BYTE;

	chk_stream_entry: assert property (
		(state_ff == fsr_pkg::FSR_ST_CMD && !cs_s2_ff && sck_rise && cmd_cnt_ff == fsr_pkg::FSR_CMD_LAST_BIT
		&& nxt_cmd == fsr_pkg::FSR_OP_STATUS_READ && !sleep_i) |=> so_oe_o)
		else $error("status opcode did not start the stream");
	chk_busy_entry: assert property (
		(state_ff == fsr_pkg::FSR_ST_CMD && !cs_s2_ff && sck_rise && cmd_cnt_ff == fsr_pkg::FSR_CMD_LAST_BIT
		&& nxt_cmd == fsr_pkg::FSR_OP_STATUS_READ && !sleep_i && op_busy_i) |=> so_oe_o ##1 so_oe_o)
		else $error("status read refused while busy");
	chk_sleep_ignore: assert property (
		(state_ff == fsr_pkg::FSR_ST_CMD && sck_rise && cmd_cnt_ff == fsr_pkg::FSR_CMD_LAST_BIT && sleep_i)
		|=> !so_oe_o)
		else $error("status read accepted while asleep");
	chk_deselect_float: assert property (
		cs_s2_ff |=> !so_oe_o)
		else $error("output still driven after deselect");
	chk_low_ready: assert property (
		load_lo |=> so_o == $past(ready_w))
		else $error("low byte ready bit wrong");
	chk_high_ready: assert property (
		load_hi |=> so_o == $past(ready_w))
		else $error("high byte ready bit wrong");
	chk_low_fields: assert property (
		load_lo |=> sh_ff[7] == $past(mismatch_ff) && sh_ff[6:3] == fsr_pkg::FSR_CAPACITY_CODE)
		else $error("compare or capacity field wrong");
	// Capacity bits leave on the third to sixth fall of the low byte
	chk_cap_code: assert property (
		(sck_fall && state_ff == fsr_pkg::FSR_ST_STREAM && bit_idx_ff >= 4'h2 && bit_idx_ff <= 4'h5)
		|=> so_o == fsr_pkg::FSR_CAPACITY_CODE[$past(bit_idx_ff[1:0]) ^ 2'h1])
		else $error("capacity code wrong");
	chk_lock_page: assert property (
		load_lo |=> sh_ff[2] == $past(protect_i) && sh_ff[1] == $past(page_binary_i))
		else $error("lock or page size bit wrong");
	chk_page_size: assert property (
		load_lo |=> sh_ff[1] == $past(page_binary_i))
		else $error("page size bit wrong");
	chk_high_fields: assert property (
		load_hi |=> sh_ff[7] == 1'b0 && sh_ff[5:4] == 2'h0 && sh_ff[6] == $past(fault_ff))
		else $error("high byte fields wrong");
	chk_fault_update: assert property (
		(wp_done_i && !wp_abort_i) |=> fault_ff == $past(wp_fail_i))
		else $error("fault bit not updated");
	chk_fault_abort: assert property (
		(wp_done_i && wp_abort_i) |=> $stable(fault_ff))
		else $error("aborted operation changed fault bit");
	// Done wins over start, so busy still covers the done cycle
	chk_compare_busy: assert property (
		(compare_start_i || (compare_run_ff && !compare_done_i)) |=> !ready_w)
		else $error("not busy during compare");
	chk_compare_result: assert property (
		compare_done_i |=> mismatch_ff == $past(compare_mismatch_i))
		else $error("compare result not stored");
	chk_byte_wrap: assert property (
		(sck_fall && state_ff == fsr_pkg::FSR_ST_STREAM && bit_idx_ff == fsr_pkg::FSR_IDX_LAST_BIT && !cs_s2_ff)
		|=> bit_idx_ff == fsr_pkg::FSR_IDX_LOW_BYTE)
		else $error("stream did not wrap to low byte");
	chk_fall_only: assert property (
		(so_oe_o && !sck_fall) |=> $stable(so_o))
		else $error("output changed off a falling edge");

	// Drive starts only after the last opcode bit, always at the low byte
	chk_oe_start: assert property (
		$rose(so_oe_o) |-> $past(sck_rise && cmd_cnt_ff == fsr_pkg::FSR_CMD_LAST_BIT)
		&& bit_idx_ff == fsr_pkg::FSR_IDX_LOW_BYTE)
		else $error("stream started at the wrong point");
	chk_stream_hold: assert property (
		(so_oe_o && !cs_s2_ff) |=> so_oe_o)
		else $error("stream stopped while selected");
	// A refused opcode keeps the pin floating until deselect
	chk_ignore_quiet: assert property (
		(state_ff == fsr_pkg::FSR_ST_IGNORE && !cs_s2_ff) |=> !so_oe_o)
		else $error("refused command drove the output");
	// Shifter must neither skip nor repeat a bit inside a byte
	chk_shift_order: assert property (
		(sck_fall && so_oe_o && bit_idx_ff[2:0] != 3'h0) |=> so_o == $past(sh_ff[7]))
		else $error("status bits left out of order");
	chk_busy_low: assert property (
		(op_busy_i || compare_run_ff) |-> !stat_lo.ready && !stat_hi.ready)
		else $error("ready shown while busy");

	cov_stream: cover property (load_lo ##[1:200] load_hi);
	cov_wrap: cover property (load_hi ##[1:200] load_lo);
	cov_mid_byte_exit: cover property (so_oe_o && bit_idx_ff == 4'he ##1 !so_oe_o);
	cov_refused: cover property (state_ff == fsr_pkg::FSR_ST_IGNORE ##1 cs_s2_ff);
	cov_poll_busy: cover property (load_lo && op_busy_i ##[1:400] load_lo && !op_busy_i);

endmodule // fsr_status_read
`default_nettype wire

// *** fsr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model (
	// System
	input wire logic clk_i,
	// Serial pins
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_i
);
	initial
	begin
		sck_o = 1'h0;
		cs_n_o = 1'h1;
		si_o = 1'h0;
	end
	task automatic half();
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	// Bits taken while the pin floats read as unknown
	task automatic read(input logic [7:0] op, input int n, output logic [31:0] d);
		d = 32'h0;
		cs_n_o = 1'h0;
		half();
		for (int i = 0; i < 8; i++)
		begin
			si_o = op[7 - i];
			half();
			sck_o = 1'h1;
			half();
			sck_o = 1'h0;
		end
		si_o = ~si_o;
		for (int i = 0; i < n; i++)
		begin
			half();
			sck_o = 1'h1;
			half();
			d = {d[30:0], so_oe_i ? so_i : 1'hx};
			sck_o = 1'h0;
		end
		half();
		cs_n_o = 1'h1;
		half();
	endtask
endmodule // fsr_host_model
`default_nettype wire

// *** tb_flash_status_register_read.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_flash_status_register_read;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic sck, cs_n, si, so, so_oe;
	logic op_busy_i = 1'h0;
	logic compare_start_i = 1'h0;
	logic compare_done_i = 1'h0;
	logic compare_mismatch_i = 1'h0;
	logic protect_i = 1'h0;
	logic page_binary_i = 1'h0;
	logic wp_done_i = 1'h0;
	logic wp_fail_i = 1'h0;
	logic wp_abort_i = 1'h0;
	logic sleep_i = 1'h0;
	int n_errors = 0;
	int num_checks = 0;
	always #20 clk_i = ~clk_i;
	fsr_status_read i_dut (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
		.so_oe_o(so_oe), .op_busy_i(op_busy_i), .compare_start_i(compare_start_i),
		.compare_done_i(compare_done_i), .compare_mismatch_i(compare_mismatch_i), .protect_i(protect_i),
		.page_binary_i(page_binary_i), .wp_done_i(wp_done_i), .wp_fail_i(wp_fail_i),
		.wp_abort_i(wp_abort_i), .sleep_i(sleep_i));
	fsr_host_model i_host (.clk_i(clk_i), .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));
	// Fields: ready, mismatch, protect, page_binary
	function automatic logic [7:0] lo(input logic [3:0] v);
		return {v[3], v[2], fsr_pkg::FSR_CAPACITY_CODE, v[1:0]};
	endfunction
	function automatic logic [7:0] hi(input logic [1:0] v);
		return {v[1], 1'h0, v[0], 5'h00};
	endfunction
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Reserved high-byte bits are masked on whole-word reads
	task automatic rd(input logic [7:0] op, input int n, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [31:0] m;
		m = (n % 16 == 0) ? 32'hfff8fff8 : 32'hffffffff;
		i_host.read(op, n, d);
		repeat (2) @(posedge clk_i);
		#1;
		chk(nm, e & m, d & m);
		chk("so_oe", 32'h0, {31'h0, so_oe});
	endtask
	// Set compare start, done, mismatch, write done, fail, abort; only start and the two dones pulse
	task automatic ev(input logic [5:0] v);
		@(posedge clk_i);
		#1;
		{compare_start_i, compare_done_i, compare_mismatch_i, wp_done_i, wp_fail_i, wp_abort_i} = v;
		@(posedge clk_i);
		#1;
		{compare_start_i, compare_done_i, wp_done_i} = 3'h0;
	endtask
	task automatic t_fields();
		protect_i = 1'h1;
		rd(8'hd7, 32, {lo(4'ha), hi(2'h2), lo(4'ha), hi(2'h2)}, "fields");
		protect_i = 1'h0;
		page_binary_i = 1'h1;
		rd(8'hd7, 16, {16'h0, lo(4'h9), hi(2'h2)}, "fields2");
	endtask
	task automatic t_busy();
		op_busy_i = 1'h1;
		fork
			rd(8'hd7, 32, {lo(4'h1), hi(2'h0), lo(4'h9), hi(2'h2)}, "busy");
			begin
				repeat (164) @(posedge clk_i);
				#1;
				op_busy_i = 1'h0;
			end
		join
	endtask
	task automatic t_cmp();
		ev(6'h20);
		rd(8'hd7, 16, {16'h0, lo(4'h1), hi(2'h0)}, "cmp_busy");
		ev(6'h18);
		rd(8'hd7, 16, {16'h0, lo(4'hd), hi(2'h2)}, "cmp_miss");
		ev(6'h10);
		rd(8'hd7, 16, {16'h0, lo(4'h9), hi(2'h2)}, "cmp_match");
	endtask
	task automatic t_fault();
		logic [5:0] evs [4] = '{6'h06, 6'h07, 6'h04, 6'h07};
		logic [3:0] f = 4'h3;
		for (int i = 0; i < 4; i++)
		begin
			ev(evs[i]);
			rd(8'hd7, 16, {16'h0, lo(4'h9), hi({1'h1, f[i]})}, "fault");
		end
	endtask
	task automatic t_edge();
		sleep_i = 1'h1;
		rd(8'hd7, 8, {24'h0, 8'hxx}, "sleep");
		sleep_i = 1'h0;
		rd(8'h0f, 8, {24'h0, 8'hxx}, "bad_op");
		rd(8'hd7, 13, {19'h0, lo(4'h9), 5'h10}, "partial");
	endtask
	initial
	begin
		repeat (5) @(posedge clk_i);
		#1;
		rst_i = 1'h0;
		repeat (4) @(posedge clk_i);
		#1;
		t_fields();
		t_busy();
		t_cmp();
		t_fault();
		t_edge();
		test_done();
	end
	// Whole run is about 2800 cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		test_done();
	end
endmodule // tb_flash_status_register_read
`default_nettype wire
